// File: design/odtc_top.sv
// Debug trigger and capture unit with boot mode selection and Wishbone registers
//
// Contract
// - After a power-on reset the block enters background mode if the debug wire is low at release.
// - Background is also forced when the force bit is set while the debug wire is already low in the next cycle.
// - Pin and error resets ignore the debug wire and start in user mode.
// - A capture FIFO holds eight entries of address or data words.
// - The debug tool reaches the control registers and the FIFO over the register port.
// - Two 16-bit comparators each may be qualified by read/write, each with its own enable.
// - With opcode tracking, a match counts only when the instruction is really executed.
// - The comparators do magnitude tests for inside and outside range modes.
// - Both comparators are disabled during every background controller access.
// - Comparator A always looks at the 16-bit CPU address.
// - Comparator B looks at the address or the 8-bit data bus, as the mode chooses.
// - In address plus data modes B uses write data when the A enable is 1 and select 0.
// - A qualified match breaks, stores data, begins trace or ends trace per the mode.
// - FIFO entries are read out in the order they were stored.
// - Status reports the count of valid words, updated as each word is stored.
// - Disarming before full with a nonzero count shifts the stored data by one.
`timescale 1ns/1ps
module odtc_top
  import odtc_pkg::*;
#(
  parameter int DEPTH = ODTC_FIFO_DEPTH
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic POR_RESET,
  input wire logic PIN_RESET,
  input wire logic ERR_RESET,
  input wire logic DEBUG_WIRE_PIN,
  input wire logic BDC_ACCESS,
  input wire odtc_cpu_bus_t CPU_BUS,
  output logic BACKGROUND_MODE,
  output logic CPU_BREAK,
  output logic IRQ,
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [5:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK
);

  // ------------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------------
  logic [31:0] ctrl;
  logic [15:0] cmpa_val;
  logic [15:0] cmpb_val;
  logic force_bgnd;
  logic [ODTC_IRQ_W-1:0] irq_stat;
  logic [ODTC_IRQ_W-1:0] irq_mask;
  logic [ODTC_WORD_W-1:0] fifo_mem [DEPTH];
  logic [ODTC_CNT_W-1:0] fifo_valid_word_count;
  logic [ODTC_CNT_W-1:0] rd_ptr;
  logic tracing;
  logic was_por;
  odtc_boot_t boot_state;

  logic wb_req;
  logic wb_wr;
  logic wb_rd;
  logic rd_fifo;
  logic rd_irq;
  logic [2:0] mode;
  logic cmp_ok;
  logic a_eq;
  logic a_ge;
  logic a_le;
  logic b_eq;
  logic b_ge;
  logic b_le;
  logic addr_mode_b;
  logic [15:0] b_bus;
  logic exec_ok;
  logic hit;
  logic do_break;
  logic do_store;
  logic [15:0] store_word;
  logic fifo_full;
  logic disarm;
  logic [ODTC_IRQ_W-1:0] irq_evt;

  assign mode = ctrl[ODTC_CTRL_MODE_HI:ODTC_CTRL_MODE_LO];
  assign wb_req = WB_CYC && WB_STB && !WB_ACK;
  assign wb_wr = wb_req && WB_WE && CE;
  assign wb_rd = wb_req && !WB_WE && CE;
  assign rd_fifo = wb_rd && (WB_ADR == ODTC_ADDR_FIFO);
  assign rd_irq = wb_rd && (WB_ADR == ODTC_ADDR_IRQS);
  assign fifo_full = (fifo_valid_word_count == ODTC_CNT_FULL);
  assign disarm = wb_wr && (WB_ADR == ODTC_ADDR_CTRL) && WB_SEL[0]
                  && !WB_DAT_I[ODTC_CTRL_ARM] && ctrl[ODTC_CTRL_ARM];

  // ------------------------------------------------------------------
  // Boot mode selection
  // ------------------------------------------------------------------
  // The pin is sampled on the cycle reset is released; only power-on counts.
  always_ff @(posedge CLK) begin
    if (RST) begin
      boot_state <= ODTC_BOOT_RESET;
      was_por <= 1'b0;
    end else if (CE) begin
      case (boot_state)
        ODTC_BOOT_RESET: begin
          if (POR_RESET) begin
            was_por <= 1'b1;
          end else if (PIN_RESET || ERR_RESET) begin
            was_por <= 1'b0;
          end else if (was_por && !DEBUG_WIRE_PIN) begin
            boot_state <= ODTC_BOOT_BGND;
          end else begin
            boot_state <= ODTC_BOOT_USER;
          end
        end
        ODTC_BOOT_USER: begin
          if (force_bgnd && !DEBUG_WIRE_PIN) begin
            boot_state <= ODTC_BOOT_BGND;
          end else if (POR_RESET || PIN_RESET || ERR_RESET) begin
            boot_state <= ODTC_BOOT_RESET;
            was_por <= POR_RESET;
          end
        end
        ODTC_BOOT_BGND: begin
          if (POR_RESET || PIN_RESET || ERR_RESET) begin
            boot_state <= ODTC_BOOT_RESET;
            was_por <= POR_RESET;
          end
        end
        default: boot_state <= ODTC_BOOT_RESET;
      endcase
    end
  end

  assign BACKGROUND_MODE = (boot_state == ODTC_BOOT_BGND);

  // Force bit is consumed by the pin check right after it is written
  always_ff @(posedge CLK) begin
    if (RST) begin
      force_bgnd <= 1'b0;
    end else if (CE) begin
      if (wb_wr && WB_ADR == ODTC_ADDR_BFRC && WB_SEL[0]) begin
        force_bgnd <= WB_DAT_I[0];
      end else if (boot_state == ODTC_BOOT_USER) begin
        force_bgnd <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Comparators
  // ------------------------------------------------------------------
  assign cmp_ok = CPU_BUS.valid && !BDC_ACCESS;
  assign addr_mode_b = (mode != ODTC_MODE_A_AND_DATA) && (mode != ODTC_MODE_STORE_AB);
  // Address in address modes; in data modes write data only when A is qualified to writes, read data otherwise
  assign b_bus = addr_mode_b ? CPU_BUS.addr :
                 (ctrl[ODTC_CTRL_CMP_A_RW_QUALIFY_ENABLE] && !ctrl[ODTC_CTRL_RWA]) ?
                 {8'h00, CPU_BUS.wdata} : {8'h00, CPU_BUS.rdata};
  assign exec_ok = !ctrl[ODTC_CTRL_OPC] || CPU_BUS.opc_exec;

  odtc_cmp #(.W(16)) u_cmp_a (
    .ref_val(cmpa_val),
    .bus_val(CPU_BUS.addr),
    .rw_en(ctrl[ODTC_CTRL_CMP_A_RW_QUALIFY_ENABLE]),
    .rw_sel(ctrl[ODTC_CTRL_RWA]),
    .bus_rw(CPU_BUS.rw),
    .bus_ok(cmp_ok),
    .eq(a_eq),
    .ge(a_ge),
    .le(a_le)
  );

  odtc_cmp #(.W(16)) u_cmp_b (
    .ref_val(addr_mode_b ? cmpb_val : {8'h00, cmpb_val[7:0]}),
    .bus_val(b_bus),
    .rw_en(ctrl[ODTC_CTRL_RWBEN]),
    .rw_sel(ctrl[ODTC_CTRL_RWB]),
    .bus_rw(CPU_BUS.rw),
    .bus_ok(cmp_ok),
    .eq(b_eq),
    .ge(b_ge),
    .le(b_le)
  );

  // ------------------------------------------------------------------
  // Trigger actions
  // ------------------------------------------------------------------
  always_comb begin
    hit = 1'b0;
    do_break = 1'b0;
    do_store = 1'b0;
    store_word = CPU_BUS.addr;
    if (ctrl[ODTC_CTRL_ARM] && exec_ok) begin
      case (mode)
        ODTC_MODE_BRK_A: begin
          hit = a_eq;
          do_break = a_eq;
        end
        ODTC_MODE_BRK_A_OR_B: begin
          hit = a_eq || b_eq;
          do_break = hit;
        end
        ODTC_MODE_IN_RANGE: begin
          hit = a_ge && b_le;
          do_break = hit;
        end
        ODTC_MODE_OUT_RANGE: begin
          hit = cmp_ok && !(a_ge && b_le);
          do_break = hit;
        end
        ODTC_MODE_STORE_AB: begin
          hit = a_eq;
          do_store = a_eq;
          store_word = {8'h00, (ctrl[ODTC_CTRL_CMP_A_RW_QUALIFY_ENABLE] && !ctrl[ODTC_CTRL_RWA]) ?
                        CPU_BUS.wdata : CPU_BUS.rdata};
        end
        ODTC_MODE_A_AND_DATA: begin
          hit = a_eq && b_eq;
          do_break = hit;
        end
        ODTC_MODE_BEGIN_A, ODTC_MODE_END_A: begin
          hit = a_eq;
          do_store = tracing && CPU_BUS.cof && cmp_ok;
        end
        default: hit = 1'b0;
      endcase
    end
  end

  assign CPU_BREAK = do_break;

  // Trace window: begin opens on A, end closes on A
  always_ff @(posedge CLK) begin
    if (RST) begin
      tracing <= 1'b0;
    end else if (CE) begin
      if (!ctrl[ODTC_CTRL_ARM]) begin
        tracing <= (mode == ODTC_MODE_END_A);
      end else if (hit && mode == ODTC_MODE_BEGIN_A) begin
        tracing <= 1'b1;
      end else if (hit && mode == ODTC_MODE_END_A) begin
        tracing <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Capture FIFO
  // ------------------------------------------------------------------
  // A shift chain keeps read order trivially equal to write order.
  always_ff @(posedge CLK) begin
    if (RST) begin
      fifo_valid_word_count <= '0;
      rd_ptr <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        fifo_mem[i] <= 16'h0000;
      end
    end else if (CE) begin
      if (wb_wr && WB_ADR == ODTC_ADDR_CTRL && WB_SEL[0] && WB_DAT_I[ODTC_CTRL_ARM]
          && !ctrl[ODTC_CTRL_ARM]) begin
        fifo_valid_word_count <= '0;
        rd_ptr <= '0;
      end else if (disarm && !fifo_full
                   && fifo_valid_word_count != '0) begin
        for (int i = 0; i < DEPTH - 1; i++) begin
          fifo_mem[i] <= fifo_mem[i+1];
        end
        fifo_mem[DEPTH-1] <= 16'h0000;
        rd_ptr <= 4'(DEPTH) - fifo_valid_word_count;
      end else if (do_store && !fifo_full) begin
        for (int i = 0; i < DEPTH - 1; i++) begin
          fifo_mem[i] <= fifo_mem[i+1];
        end
        fifo_mem[DEPTH-1] <= store_word;
        fifo_valid_word_count <= fifo_valid_word_count + 4'h1;
      end else if (rd_fifo && !ctrl[ODTC_CTRL_ARM] && rd_ptr < 4'(DEPTH)) begin
        rd_ptr <= rd_ptr + 4'h1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Interrupt flags
  // ------------------------------------------------------------------
  assign irq_evt = {do_store && !fifo_full, do_store && fifo_valid_word_count ==
                    ODTC_CNT_FULL - 4'h1, do_break};

  // An event in the clearing read cycle survives
  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_stat <= '0;
    end else if (CE) begin
      irq_stat <= (rd_irq ? '0 : irq_stat) | irq_evt;
    end
  end

  assign IRQ = |(irq_stat & irq_mask);

  // ------------------------------------------------------------------
  // Wishbone slave
  // ------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl <= ODTC_CTRL_RESET;
      cmpa_val <= 16'h0000;
      cmpb_val <= 16'h0000;
      irq_mask <= '0;
    end else if (wb_wr) begin
      case (WB_ADR)
        ODTC_ADDR_CTRL: begin
          if (WB_SEL[0]) ctrl[7:0] <= WB_DAT_I[7:0] & ODTC_CTRL_MASK[7:0];
          if (WB_SEL[1]) ctrl[15:8] <= WB_DAT_I[15:8] & ODTC_CTRL_MASK[15:8];
        end
        ODTC_ADDR_CMPA: begin
          if (WB_SEL[0]) cmpa_val[7:0] <= WB_DAT_I[7:0];
          if (WB_SEL[1]) cmpa_val[15:8] <= WB_DAT_I[15:8];
        end
        ODTC_ADDR_CMPB: begin
          if (WB_SEL[0]) cmpb_val[7:0] <= WB_DAT_I[7:0];
          if (WB_SEL[1]) cmpb_val[15:8] <= WB_DAT_I[15:8];
        end
        ODTC_ADDR_IRQM: begin
          if (WB_SEL[0]) irq_mask <= WB_DAT_I[ODTC_IRQ_W-1:0];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      WB_ACK <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else if (CE) begin
      WB_ACK <= wb_req;
      WB_DAT_O <= 32'h0000_0000;
      if (wb_rd) begin
        case (WB_ADR)
          ODTC_ADDR_CTRL: WB_DAT_O <= ctrl;
          ODTC_ADDR_CMPA: WB_DAT_O <= {16'h0000, cmpa_val};
          ODTC_ADDR_CMPB: WB_DAT_O <= {16'h0000, cmpb_val};
          ODTC_ADDR_FIFO: begin
            if (!ctrl[ODTC_CTRL_ARM] && rd_ptr < 4'(DEPTH)) begin
              WB_DAT_O <= {16'h0000, fifo_mem[rd_ptr[2:0]]};
            end
          end
          ODTC_ADDR_STAT: WB_DAT_O <= {20'h00000, rd_ptr, 3'h0, tracing,
                                       fifo_valid_word_count};
          ODTC_ADDR_IRQS: WB_DAT_O <= {29'h00000000, irq_stat};
          ODTC_ADDR_IRQM: WB_DAT_O <= {29'h00000000, irq_mask};
          ODTC_ADDR_BFRC: WB_DAT_O <= {31'h00000000, force_bgnd};
          default: WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // odtc_top

// File: shared/odtc_pkg.sv
// Package for the on-chip debug trigger and capture block
package odtc_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses on the Wishbone slave)
  // ------------------------------------------------------------------
  localparam logic [5:0] ODTC_ADDR_CTRL = 6'h00;
  localparam logic [5:0] ODTC_ADDR_CMPA = 6'h04;
  localparam logic [5:0] ODTC_ADDR_CMPB = 6'h08;
  localparam logic [5:0] ODTC_ADDR_FIFO = 6'h0c;
  localparam logic [5:0] ODTC_ADDR_STAT = 6'h10;
  localparam logic [5:0] ODTC_ADDR_IRQS = 6'h14;
  localparam logic [5:0] ODTC_ADDR_IRQM = 6'h18;
  localparam logic [5:0] ODTC_ADDR_BFRC = 6'h1c;

  // ------------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------------
  localparam int ODTC_CTRL_ARM = 0;
  localparam int ODTC_CTRL_CMP_A_RW_QUALIFY_ENABLE = 1;
  localparam int ODTC_CTRL_RWA = 2;
  localparam int ODTC_CTRL_RWBEN = 3;
  localparam int ODTC_CTRL_RWB = 4;
  localparam int ODTC_CTRL_OPC = 5;
  localparam int ODTC_CTRL_MODE_LO = 8;
  localparam int ODTC_CTRL_MODE_HI = 10;
  localparam logic [31:0] ODTC_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] ODTC_CTRL_MASK = 32'h0000_073f;

  // Trigger modes
  localparam logic [2:0] ODTC_MODE_BRK_A = 3'h0;
  localparam logic [2:0] ODTC_MODE_STORE_AB = 3'h1;
  localparam logic [2:0] ODTC_MODE_BEGIN_A = 3'h2;
  localparam logic [2:0] ODTC_MODE_END_A = 3'h3;
  localparam logic [2:0] ODTC_MODE_IN_RANGE = 3'h4;
  localparam logic [2:0] ODTC_MODE_OUT_RANGE = 3'h5;
  localparam logic [2:0] ODTC_MODE_A_AND_DATA = 3'h6;
  localparam logic [2:0] ODTC_MODE_BRK_A_OR_B = 3'h7;

  // ------------------------------------------------------------------
  // Interrupt status bits
  // ------------------------------------------------------------------
  localparam int ODTC_IRQ_BRK = 0;
  localparam int ODTC_IRQ_FULL = 1;
  localparam int ODTC_IRQ_CAPT = 2;
  localparam int ODTC_IRQ_W = 3;

  // Fifo geometry and count values
  localparam int ODTC_FIFO_DEPTH = 8;
  localparam int ODTC_CNT_W = 4;
  localparam int ODTC_WORD_W = 16;
  localparam logic [3:0] ODTC_CNT_FULL = 4'h8;
  localparam logic [3:0] ODTC_CNT_ONE = 4'h1;

  // CPU bus snapshot
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rw;
    logic valid;
    logic opc_exec;
    logic cof;
  } odtc_cpu_bus_t;

  // Boot mode states
  typedef enum logic [2:0] {
    ODTC_BOOT_RESET = 3'b001,
    ODTC_BOOT_USER = 3'b010,
    ODTC_BOOT_BGND = 3'b100
  } odtc_boot_t;

endpackage

// File: design/odtc_cmp.sv
// One 16-bit comparator with read/write qualification and magnitude output
`timescale 1ns/1ps
module odtc_cmp
  import odtc_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic [W-1:0] ref_val,
  input wire logic [W-1:0] bus_val,
  input wire logic rw_en,
  input wire logic rw_sel,
  input wire logic bus_rw,
  input wire logic bus_ok,
  output logic eq,
  output logic ge,
  output logic le
);

  logic rw_ok;

  assign rw_ok = !rw_en || (bus_rw == rw_sel);
  assign eq = bus_ok && rw_ok && (bus_val == ref_val);
  assign ge = bus_ok && rw_ok && (bus_val >= ref_val);
  assign le = bus_ok && rw_ok && (bus_val <= ref_val);

endmodule // odtc_cmp

// File: verification/odtc_top_sva.sv
// Port-level assertions for the debug trigger and capture block
`timescale 1ns/1ps
module odtc_top_sva
  import odtc_pkg::*;
#(
  parameter int DEPTH = ODTC_FIFO_DEPTH
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic BDC_ACCESS,
  input wire logic BACKGROUND_MODE,
  input wire logic CPU_BREAK,
  input wire logic IRQ,
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [5:0] WB_ADR,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  wire take = WB_CYC && WB_STB && !WB_ACK && CE;
  // ------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------
  ack_after_take_a: assert property (take |=> WB_ACK)
    else $error("no ack one cycle after a taken request");
  ack_one_shot_a: assert property (WB_ACK |=> !WB_ACK)
    else $error("ack held longer than one cycle");
  ack_needs_take_a: assert property (!take |=> !WB_ACK)
    else $error("ack without a taken request");
  unmapped_reads_zero_a: assert property (
    WB_ACK && !$past(WB_WE) && $past(WB_ADR) > 6'h1c |-> WB_DAT_O == 32'h0)
    else $error("unmapped read returned nonzero data");
  // ------------------------------------------------------------
  // Trigger outputs and reset
  // ------------------------------------------------------------
  brk_in_bdc_a: assert property (BDC_ACCESS |-> !CPU_BREAK)
    else $error("breakpoint during a background access");
  brk_in_rst_a: assert property (disable iff (1'b0) RST |-> !CPU_BREAK)
    else $error("breakpoint while in reset");
  ack_in_rst_a: assert property (disable iff (1'b0) RST |=> !WB_ACK)
    else $error("ack while in reset");
  outs_in_rst_a: assert property (disable iff (1'b0) RST [*2] |-> !IRQ && !BACKGROUND_MODE)
    else $error("irq or background mode set during reset");
  cover property (take ##1 WB_ACK);
  cover property ($rose(IRQ));
  cover property ($rose(BACKGROUND_MODE));
endmodule // odtc_top_sva

bind odtc_top odtc_top_sva #(.DEPTH(DEPTH)) i_odtc_top_sva (.CLK(CLK), .RST(RST), .CE(CE),
  .BDC_ACCESS(BDC_ACCESS), .BACKGROUND_MODE(BACKGROUND_MODE), .CPU_BREAK(CPU_BREAK),
  .IRQ(IRQ), .WB_CYC(WB_CYC), .WB_STB(WB_STB), .WB_WE(WB_WE), .WB_ADR(WB_ADR),
  .WB_DAT_O(WB_DAT_O), .WB_ACK(WB_ACK));

// File: verification/odtc_pod.sv
// Behavioural debug pod on the single-wire debug link
`timescale 1ns/1ps
module odtc_pod (
  input wire logic clk,
  input wire logic hold_low,
  input wire logic access_req,
  output logic pin_out = 1'b1,
  output logic access
);
  // The wire has a pull-up, so a released pod reads high
  always @(posedge clk) begin
    pin_out <= !hold_low;
  end
  assign access = access_req;
endmodule // odtc_pod

// File: verification/tb_odtc_top.sv
// Self-checking bench for the debug trigger and capture block
`timescale 1ns/1ps
module tb_odtc_top;
  import odtc_pkg::*;
  typedef struct packed {logic [31:0] e; logic [31:0] m;} odtc_note_t;
  logic clk = 0, rst = 1, ce = 1, por = 0, pinr = 0, errr = 0, hold_low = 0, acc_req = 0;
  logic cyc = 0, stb = 0, we = 0, ack, bg, brk, irq, pin, bdc;
  logic [5:0] adr = 6'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] dati = 32'h0, dato, r;
  logic [15:0] a;
  logic [15:0] lo, hi;
  logic [15:0] tr [3];
  logic [7:0] d;
  logic [7:0] rd_data [10];
  odtc_cpu_bus_t bus = '0;
  odtc_note_t q[$];
  int fails = 0, n_checks = 0;
  always #4 clk = ~clk;
  odtc_pod i_odtc_pod (.clk(clk), .hold_low(hold_low), .access_req(acc_req), .pin_out(pin),
    .access(bdc));
  odtc_top i_odtc_top (.CLK(clk), .RST(rst), .CE(ce), .POR_RESET(por), .PIN_RESET(pinr),
    .ERR_RESET(errr), .DEBUG_WIRE_PIN(pin), .BDC_ACCESS(bdc), .CPU_BUS(bus),
    .BACKGROUND_MODE(bg), .CPU_BREAK(brk), .IRQ(irq), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we),
    .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_I(dati), .WB_DAT_O(dato), .WB_ACK(ack));
  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Read results are matched against the oldest note
  always @(posedge clk) begin
    odtc_note_t nt;
    if (ack === 1'b1 && we === 1'b0) begin
      nt = q.pop_front();
      chk(dato & nt.m, nt.e, "read data");
    end
  end
  task automatic wb(input logic w, input logic [5:0] ad, input logic [31:0] d,
                    input logic [31:0] m);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    dati <= d;
    if (!w) q.push_back({d & m, m});
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) begin
      fails++;
      report_and_stop();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_for(input int which, input logic v);
    int n;
    n = 0;
    while ((which == 0 ? bg : irq) !== v && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) begin
      fails++;
      report_and_stop();
    end
  endtask
  // One CPU bus cycle with the break output checked in mid-cycle
  task automatic cpu(input odtc_cpu_bus_t b, input logic exp_brk);
    bus <= b;
    @(negedge clk);
    chk({31'h0, brk}, {31'h0, exp_brk}, "break output");
    @(posedge clk);
  endtask
  // Cause 0 is power-on, 1 pin, 2 error reset
  task automatic boot(input int cause, input logic low);
    rst <= 1'b1;
    por <= (cause == 0);
    pinr <= (cause == 1);
    errr <= (cause == 2);
    hold_low <= low;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    {por, pinr, errr} <= 3'b000;
    repeat (4) @(posedge clk);
    wait_for(0, low && cause == 0);
    chk({31'h0, bg}, {31'h0, low && cause == 0}, "boot mode");
    hold_low <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32893));
    for (int c = 0; c < 3; c++) boot(c, 1'b1);
    boot(0, 1'b0);
    // The pod pulls the wire low as the force command lands
    hold_low <= 1'b1;
    wb(1'b1, ODTC_ADDR_BFRC, 32'h1, '0);
    wait_for(0, 1'b1);
    chk({31'h0, bg}, 32'h1, "forced background");
    boot(0, 1'b0);
    r = $urandom() & 32'hffff_fffe;
    wb(1'b1, ODTC_ADDR_CTRL, r, '0);
    wb(1'b0, ODTC_ADDR_CTRL, r & ODTC_CTRL_MASK, '1);
    r = $urandom();
    wb(1'b1, ODTC_ADDR_CMPA, r, '0);
    wb(1'b0, ODTC_ADDR_CMPA, r, 32'hffff);
    wb(1'b1, 6'h20, r, '0);
    wb(1'b0, 6'h20, 32'h0, '1);
    // Background access and a write cycle must not store; ten reads overfill
    a = $urandom();
    wb(1'b1, ODTC_ADDR_CMPA, {16'h0, a}, '0);
    wb(1'b1, ODTC_ADDR_CTRL, 32'h0107, '0);
    acc_req <= 1'b1;
    bus <= {a, 8'h00, 8'h5a, 4'b1110};
    @(posedge clk);
    acc_req <= 1'b0;
    bus.rw <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      rd_data[i] = $urandom();
      bus <= {a, 8'h00, rd_data[i], 4'b1110};
      @(posedge clk);
    end
    bus <= '0;
    wb(1'b0, ODTC_ADDR_STAT, {28'h0, ODTC_CNT_FULL}, 32'hf);
    wb(1'b0, ODTC_ADDR_IRQS, (32'h1 << ODTC_IRQ_FULL) | (32'h1 << ODTC_IRQ_CAPT), 32'h7);
    wb(1'b1, ODTC_ADDR_CTRL, 32'h0106, '0);
    for (int i = 0; i < 8; i++) wb(1'b0, ODTC_ADDR_FIFO, {24'h0, rd_data[i]}, 32'hff);
    // Breakpoints with opcode tracking: A alone, A or B, then with the irq masked
    for (int m = 0; m < 3; m++) begin
      a = $urandom();
      wb(1'b1, ODTC_ADDR_IRQM, {31'h0, m < 2}, '0);
      wb(1'b1, m == 1 ? ODTC_ADDR_CMPB : ODTC_ADDR_CMPA, {16'h0, a}, '0);
      wb(1'b1, ODTC_ADDR_CTRL, m == 1 ? 32'h0721 : 32'h0021, '0);
      bus <= {a, 16'h0, 4'b1100};
      @(negedge clk);
      chk({31'h0, brk}, 32'h0, "fetch only");
      @(posedge clk);
      bus <= {a, 16'h0, 4'b1110};
      @(negedge clk);
      chk({31'h0, brk}, 32'h1, "breakpoint");
      @(posedge clk);
      bus <= '0;
      if (m < 2) wait_for(1, 1'b1);
      else repeat (4) @(posedge clk);
      chk({31'h0, irq}, {31'h0, m < 2}, "irq raised");
      wb(1'b0, ODTC_ADDR_IRQS, 32'h1, 32'h1);
      wait_for(1, 1'b0);
      chk({31'h0, irq}, 32'h0, "irq cleared");
    end
    // Range modes, address plus write data, then a begin trace halted early
    a = $urandom();
    lo = {1'b0, a[14:0]};
    hi = lo + 16'h0100;
    d = $urandom();
    wb(1'b1, ODTC_ADDR_CMPA, {16'h0, lo}, '0);
    wb(1'b1, ODTC_ADDR_CMPB, {16'h0, hi}, '0);
    wb(1'b1, ODTC_ADDR_CTRL, 32'h0401, '0);
    cpu({lo, 16'h0, 4'b1110}, 1'b1);
    cpu({hi + 16'h1, 16'h0, 4'b1110}, 1'b0);
    cpu({lo - 16'h1, 16'h0, 4'b1110}, 1'b0);
    bus <= '0;
    wb(1'b1, ODTC_ADDR_CTRL, 32'h0501, '0);
    cpu({hi + 16'h1, 16'h0, 4'b1110}, 1'b1);
    cpu({hi, 16'h0, 4'b1110}, 1'b0);
    bus <= '0;
    wb(1'b1, ODTC_ADDR_CMPB, {24'h0, d}, '0);
    wb(1'b1, ODTC_ADDR_CTRL, 32'h0603, '0);
    cpu({lo, d, ~d, 4'b0110}, 1'b1);
    cpu({lo, ~d, d, 4'b0110}, 1'b0);
    bus <= '0;
    wb(1'b1, ODTC_ADDR_CTRL, 32'h0200, '0);
    wb(1'b1, ODTC_ADDR_CTRL, 32'h0201, '0);
    cpu({~lo, 16'h0, 4'b1111}, 1'b0);
    cpu({lo, 16'h0, 4'b1110}, 1'b0);
    for (int i = 0; i < 3; i++) begin
      tr[i] = $urandom();
      cpu({tr[i], 16'h0, 4'b1111}, 1'b0);
    end
    bus <= '0;
    wb(1'b1, ODTC_ADDR_CTRL, 32'h0200, '0);
    wb(1'b0, ODTC_ADDR_STAT, 32'h3, 32'hf);
    for (int i = 1; i < 3; i++) wb(1'b0, ODTC_ADDR_FIFO, {16'h0, tr[i]}, 32'hffff);
    report_and_stop();
  end
endmodule // tb_odtc_top
